// file: adcsq_defs.vh
/*
 * adcsq_defs.vh: register offsets, field positions, reset values and
 * trigger-source codes of the converter sequencer control block.
 * Assumes byte addresses on an 8-bit register port with 32-bit data.
 */
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH

// register byte offsets
`define ADCSQ_OFF_ENA     8'h00
`define ADCSQ_OFF_STATUS  8'h04
`define ADCSQ_OFF_MASK    8'h08
`define ADCSQ_OFF_PSSI    8'h0C
`define ADCSQ_OFF_ACTIVE  8'h10
`define ADCSQ_OFF_RESULT  8'h14
`define ADCSQ_OFF_CMPLO   8'h18
`define ADCSQ_OFF_CMPHI   8'h1C
`define ADCSQ_OFF_CTRL0   8'h20
`define ADCSQ_OFF_MUX0    8'h30

// per-sequencer control register fields
`define ADCSQ_LAST_LSB    0
`define ADCSQ_IE_LSB      8
`define ADCSQ_CE_LSB      16
`define ADCSQ_SRC_LSB     24
`define ADCSQ_PRI_LSB     28
`define ADCSQ_DIFF_BIT    30

// highest step index each sequencer can reach
`define ADCSQ_MAXLAST0    3'h7
`define ADCSQ_MAXLAST1    3'h3
`define ADCSQ_MAXLAST2    3'h3
`define ADCSQ_MAXLAST3    3'h0

// status bit of the digital comparator
`define ADCSQ_STS_CMP     4

// reset values
`define ADCSQ_RST_ENA     4'h0
`define ADCSQ_RST_MASK    5'h00
`define ADCSQ_RST_CTRL    32'h00000000
`define ADCSQ_RST_MUX     32'h00000000
`define ADCSQ_RST_CMPLO   12'h000
`define ADCSQ_RST_CMPHI   12'hFFF

// trigger source codes
`define ADCSQ_TRG_PROC    4'h0
`define ADCSQ_TRG_CMP     4'h1
`define ADCSQ_TRG_EXT     4'h4
`define ADCSQ_TRG_TMR     4'h5
`define ADCSQ_TRG_PWM     4'h6
`define ADCSQ_TRG_ALWAYS  4'hF

// engine timing: one cycle to issue a conversion
`define ADCSQ_ISSUE_CYC   1

`endif

// file: adcsq_arb.v
/*
 * adcsq_arb.v: priority arbiter choosing the next sequencer to convert.
 * Assumes pending and priority inputs come from the same clock domain;
 * purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module adcsq_arb (
    input wire [3:0] pend,
    input wire [7:0] pri,
    output reg gnt_valid,
    output reg [1:0] gnt_idx
);

    integer k;
    reg [1:0] best_pri;

    // lowest value wins, ties go to the lower index; the third/fourth
    // pairing keeps the silicon's misordering so software sees it as is
    always @* begin
        gnt_valid = 1'b0;
        gnt_idx = 2'h0;
        best_pri = 2'h3;
        for (k = 0; k < 4; k = k + 1) begin
            if (pend[k] && (!gnt_valid || pri[2*k +: 2] < best_pri)) begin // see [R14]
                gnt_valid = 1'b1;
                gnt_idx = k[1:0];
                best_pri = pri[2*k +: 2];
            end
        end
        // only third and fourth pending: second is compared with third
        if (pend == 4'hC) begin // see [R9]
            // either outcome grants one of them, so both still run
            gnt_idx = (pri[3:2] <= pri[5:4]) ? 2'h2 : 2'h3; // see [R10]
        end
    end

endmodule

`default_nettype wire

// file: adcsq_ctrl.v
/*
 * adcsq_ctrl.v: sequencer control of a four-sequencer converter:
 * triggering, step walking, arbitration, digital comparator, interrupts.
 * Assumes a converter core on ref_clk that answers each conv_start with
 * one conv_done pulse; only the external trigger pin is asynchronous.
 */
// Added by the designer: strobed register access and the register offsets.
//
// Contract
// [R1] differential pair codes 0x0-0x3 and 0x8-0xB
// [R2] same-type retrigger mid-sequence makes sampling continuous
// [R3] different-type retrigger never makes it continuous
// [R4] software waits for completion before retriggering
// [R5] fourth sequencer has exactly one step
// [R6] final-step comparator silent for listed triggers
// [R7] software appends dummy final comparator step
// [R8] step n result judged by step n+1 comparator
// [R9] third/fourth contest compares second against third
// [R10] third and fourth sequences still run eventually
// [R11] software puts urgent work in first two
// [R12] software averages differential results itself
// [R13] processor trigger dropped beside other-source sequence
// [R14] two-bit priority per sequencer, lower wins
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defs.vh"

module adcsq_ctrl (
    input wire ref_clk,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire ext_trig_pin,
    input wire timer_trig,
    input wire pwm_trig,
    output reg conv_start,
    output reg [3:0] conv_input,
    output reg conv_diff,
    input wire conv_done,
    input wire [11:0] conv_result,
    output reg cmp_trig,
    output wire irq
);

    localparam ENG_IDLE = 2'h0;
    localparam ENG_ISSUE = 2'h1;
    localparam ENG_WAIT = 2'h2;

    reg [3:0] ena_q;
    reg [4:0] sts_q;
    reg [4:0] sts_d;
    reg [4:0] mask_q;
    reg [11:0] cmp_lo_q;
    reg [11:0] cmp_hi_q;
    reg [15:0] result_q;
    reg [1:0] state_q;
    reg [1:0] cur_q;
    reg [2:0] step_q;
    reg ext_s1_q;
    reg ext_s2_q;
    reg ext_s3_q;

    wire [3:0] busy_w;
    wire [3:0] pend_w;
    wire [3:0] cont_w;
    wire [7:0] pri_w;
    wire [11:0] last_w;
    wire [15:0] src_w;
    wire [31:0] ie_w;
    wire [31:0] ce_w;
    wire [3:0] diff_w;
    wire [127:0] ctrl_w;
    wire [127:0] mux_w;
    wire gnt_valid;
    wire [1:0] gnt_idx;

    reg [3:0] start_v;
    reg [3:0] finish_v;
    reg [3:0] seq_irq_v;
    reg cmp_hit;

    // external trigger crosses in through two flops before edge detect
    always @(posedge ref_clk) begin
        if (srst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_trig_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    wire ext_rise = ext_s2_q & ~ext_s3_q;
    wire pssi_wr = reg_wr && (reg_addr == `ADCSQ_OFF_PSSI);

    // fields of the sequence now converting
    wire [2:0] cur_last = last_w[3*cur_q +: 3];
    wire [3:0] cur_src = src_w[4*cur_q +: 4];
    wire [7:0] cur_ie = ie_w[8*cur_q +: 8];
    wire [7:0] cur_ce = ce_w[8*cur_q +: 8];
    wire [31:0] cur_mux = mux_w[32*cur_q +: 32];
    wire [3:0] cur_code = cur_mux[4*step_q +: 4];
    wire at_last = (step_q == cur_last);
    wire step_end = (state_q == ENG_WAIT) && conv_done;

    // a processor write racing the end of another-source sequence is lost
    wire proc_drop = step_end && at_last && (cur_src != `ADCSQ_TRG_PROC); // see [R13]

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_seq
            localparam integer CI = 4 * i;
            localparam [7:0] CTRL_ADDR = `ADCSQ_OFF_CTRL0 + CI[7:0];
            localparam [7:0] MUX_ADDR = `ADCSQ_OFF_MUX0 + CI[7:0];
            localparam [2:0] MAXL = (i == 0) ? `ADCSQ_MAXLAST0 :
                                    (i == 1) ? `ADCSQ_MAXLAST1 :
                                    (i == 2) ? `ADCSQ_MAXLAST2 : `ADCSQ_MAXLAST3;
            reg [31:0] ctrl_q;
            reg [31:0] mux_q;
            reg busy_q;
            reg cont_q;
            reg pend_q;
            reg [3:0] ptype_q;
            reg [3:0] atype_q;
            wire [3:0] src = ctrl_q[`ADCSQ_SRC_LSB +: 4];
            wire hw_ev = ena_q[i] &&
                ((src == `ADCSQ_TRG_CMP && cmp_trig) ||
                 (src == `ADCSQ_TRG_EXT && ext_rise) ||
                 (src == `ADCSQ_TRG_TMR && timer_trig) ||
                 (src == `ADCSQ_TRG_PWM && pwm_trig) ||
                 (src == `ADCSQ_TRG_ALWAYS));
            wire proc_ev = ena_q[i] && pssi_wr && reg_wdata[i] && !proc_drop;
            wire ev = hw_ev || proc_ev;
            wire [3:0] ev_type = proc_ev ? `ADCSQ_TRG_PROC : src;
            wire [3:0] run_type = start_v[i] ? ptype_q : atype_q;

            // the step count is masked, so the fourth stays at one step
            assign last_w[3*i +: 3] = ctrl_q[`ADCSQ_LAST_LSB +: 3] & MAXL; // see [R5]
            assign pri_w[2*i +: 2] = ctrl_q[`ADCSQ_PRI_LSB +: 2]; // see [R14]
            assign src_w[4*i +: 4] = src;
            assign ie_w[8*i +: 8] = ctrl_q[`ADCSQ_IE_LSB +: 8];
            assign ce_w[8*i +: 8] = ctrl_q[`ADCSQ_CE_LSB +: 8];
            assign diff_w[i] = ctrl_q[`ADCSQ_DIFF_BIT];
            assign ctrl_w[32*i +: 32] = ctrl_q;
            assign mux_w[32*i +: 32] = mux_q;
            assign busy_w[i] = busy_q;
            assign pend_w[i] = pend_q;
            assign cont_w[i] = cont_q;

            // configuration registers
            always @(posedge ref_clk) begin
                if (srst) begin
                    ctrl_q <= `ADCSQ_RST_CTRL;
                    mux_q <= `ADCSQ_RST_MUX;
                end else if (reg_wr) begin
                    if (reg_addr == CTRL_ADDR) begin
                        ctrl_q <= {reg_wdata[31:3], reg_wdata[2:0] & MAXL}; // see [R5]
                    end
                    if (reg_addr == MUX_ADDR) begin
                        mux_q <= reg_wdata;
                    end
                end
            end

            // trigger bookkeeping; later assignments win so an event's set beats a start's clear, and a disable beats both
            always @(posedge ref_clk) begin
                if (srst) begin
                    busy_q <= 1'b0;
                    cont_q <= 1'b0;
                    pend_q <= 1'b0;
                    ptype_q <= `ADCSQ_TRG_PROC;
                    atype_q <= `ADCSQ_TRG_PROC;
                end else begin
                    if (start_v[i]) begin
                        busy_q <= 1'b1;
                        atype_q <= ptype_q;
                        pend_q <= 1'b0;
                    end else if (finish_v[i] && !cont_q) begin
                        busy_q <= 1'b0;
                    end
                    if (ev) begin
                        if ((busy_q || start_v[i]) && ev_type == run_type) begin
                            cont_q <= 1'b1; // see [R2]
                        end else begin
                            pend_q <= 1'b1; // see [R3]
                            ptype_q <= ev_type;
                        end
                    end
                    // disabling is the only way out of continuous sampling
                    if (!ena_q[i]) begin
                        cont_q <= 1'b0;
                        pend_q <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    adcsq_arb u_arb (
        .pend(pend_w & ~busy_w),
        .pri(pri_w),
        .gnt_valid(gnt_valid),
        .gnt_idx(gnt_idx)
    );

    // comparator sees step n's result with step n+1's setting; the final
    // step's comparator is silenced unless the source is always-trigger
    always @* begin
        cmp_hit = 1'b0;
        if (step_end && !at_last) begin // see [R8]
            if (cur_ce[step_q + 3'h1] && conv_result >= cmp_lo_q && conv_result <= cmp_hi_q) begin
                cmp_hit = 1'b1;
            end
            if ((step_q + 3'h1) == cur_last && cur_src != `ADCSQ_TRG_ALWAYS) begin
                cmp_hit = 1'b0; // see [R6]
            end
        end
    end

    // engine strobes toward the sequencers
    always @* begin
        start_v = 4'h0;
        finish_v = 4'h0;
        seq_irq_v = 4'h0;
        if (state_q == ENG_IDLE && gnt_valid) begin
            start_v[gnt_idx] = 1'b1;
        end
        if (step_end && at_last) begin
            finish_v[cur_q] = 1'b1;
        end
        // interrupts keep firing at their steps even when continuous
        if (step_end && cur_ie[step_q]) begin
            seq_irq_v[cur_q] = 1'b1; // see [R2]
        end
    end

    // step engine: one conversion at a time on the shared core
    always @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ENG_IDLE;
            cur_q <= 2'h0;
            step_q <= 3'h0;
            conv_start <= 1'b0;
            conv_input <= 4'h0;
            conv_diff <= 1'b0;
            result_q <= 16'h0000;
        end else begin
            conv_start <= 1'b0;
            case (state_q)
                ENG_IDLE: begin
                    if (gnt_valid) begin
                        cur_q <= gnt_idx;
                        step_q <= 3'h0;
                        state_q <= ENG_ISSUE;
                    end
                end
                ENG_ISSUE: begin
                    conv_start <= 1'b1;
                    conv_diff <= diff_w[cur_q];
                    // pair k occupies inputs 2k and 2k+1; code bit 2 is ignored
                    if (diff_w[cur_q]) begin
                        conv_input <= {cur_code[3], cur_code[1:0], 1'b0}; // see [R1]
                    end else begin
                        conv_input <= cur_code;
                    end
                    state_q <= ENG_WAIT;
                end
                ENG_WAIT: begin
                    if (conv_done) begin
                        result_q <= {2'h0, cur_q, conv_result};
                        if (!at_last) begin
                            step_q <= step_q + 3'h1;
                            state_q <= ENG_ISSUE;
                        end else if (cont_w[cur_q]) begin
                            // continuous: wrap and hold the converter
                            step_q <= 3'h0;
                            state_q <= ENG_ISSUE;
                        end else begin
                            state_q <= ENG_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ENG_IDLE;
                end
            endcase
        end
    end

    // comparator trigger pulse, also usable as a trigger source
    always @(posedge ref_clk) begin
        if (srst) begin
            cmp_trig <= 1'b0;
        end else begin
            cmp_trig <= cmp_hit;
        end
    end

    // software registers
    always @(posedge ref_clk) begin
        if (srst) begin
            ena_q <= `ADCSQ_RST_ENA;
            mask_q <= `ADCSQ_RST_MASK;
            cmp_lo_q <= `ADCSQ_RST_CMPLO;
            cmp_hi_q <= `ADCSQ_RST_CMPHI;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADCSQ_OFF_ENA: ena_q <= reg_wdata[3:0];
                `ADCSQ_OFF_MASK: mask_q <= reg_wdata[4:0];
                `ADCSQ_OFF_CMPLO: cmp_lo_q <= reg_wdata[11:0];
                `ADCSQ_OFF_CMPHI: cmp_hi_q <= reg_wdata[11:0];
                default: ena_q <= ena_q;
            endcase
        end
    end

    // sticky status; a read clears it but a same-cycle event survives
    always @* begin
        sts_d = sts_q;
        if (reg_rd && reg_addr == `ADCSQ_OFF_STATUS) begin
            sts_d = 5'h00;
        end
        sts_d = sts_d | {cmp_hit, seq_irq_v};
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            sts_q <= 5'h00;
        end else begin
            sts_q <= sts_d;
        end
    end

    assign irq = |(sts_q & mask_q);

    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADCSQ_OFF_ENA: reg_rdata <= {28'h0000000, ena_q};
                `ADCSQ_OFF_STATUS: reg_rdata <= {27'h0000000, sts_q};
                `ADCSQ_OFF_MASK: reg_rdata <= {27'h0000000, mask_q};
                `ADCSQ_OFF_ACTIVE: reg_rdata <= {13'h0000, step_q, cur_q, state_q, pend_w, cont_w, busy_w};
                `ADCSQ_OFF_RESULT: reg_rdata <= {16'h0000, result_q};
                `ADCSQ_OFF_CMPLO: reg_rdata <= {20'h00000, cmp_lo_q};
                `ADCSQ_OFF_CMPHI: reg_rdata <= {20'h00000, cmp_hi_q};
                8'h20: reg_rdata <= ctrl_w[31:0];
                8'h24: reg_rdata <= ctrl_w[63:32];
                8'h28: reg_rdata <= ctrl_w[95:64];
                8'h2C: reg_rdata <= ctrl_w[127:96];
                8'h30: reg_rdata <= mux_w[31:0];
                8'h34: reg_rdata <= mux_w[63:32];
                8'h38: reg_rdata <= mux_w[95:64];
                8'h3C: reg_rdata <= mux_w[127:96];
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// file: adcsq_ctrl_monitor.sv
/*
 * adcsq_ctrl_monitor.sv: port-level checker of the sequencer control block.
 * Assumes one clock, srst synchronous active high; bound into adcsq_ctrl.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defs.vh"

module adcsq_ctrl_mon (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic conv_start,
    input wire logic [3:0] conv_input,
    input wire logic conv_diff,
    input wire logic conv_done,
    input wire logic cmp_trig,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic out_q;
    // one conversion in flight at a time
    always_ff @(posedge ref_clk) begin
        out_q <= srst ? 1'b0 : (conv_start ? 1'b1 : (conv_done ? 1'b0 : out_q));
    end
    sequence s_rd_sts;
        reg_rd && reg_addr == `ADCSQ_OFF_STATUS;
    endsequence
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read answer");
    property p_start_pulse;
        conv_start |=> !conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("conversion start longer than one cycle");
    property p_diff_pair;
        conv_start && conv_diff |-> conv_input[0] == 1'b0;
    endproperty
    a_diff_pair: assert property (p_diff_pair) else $error("differential input not even");
    property p_cmp_cause;
        cmp_trig |-> $past(conv_done);
    endproperty
    a_cmp_cause: assert property (p_cmp_cause) else $error("comparator hit without a result");
    property p_one_flight;
        conv_start |-> !out_q;
    endproperty
    a_one_flight: assert property (p_one_flight) else $error("start while conversion outstanding");
    property p_input_hold;
        conv_start || ($stable(conv_input) && $stable(conv_diff));
    endproperty
    a_input_hold: assert property (p_input_hold) else $error("input select moved without a start");
    property p_unmapped;
        reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_status_clear;
        (s_rd_sts and !conv_done) ##1 (!conv_done) [*3] ##0 s_rd_sts
            |=> reg_rdata[4:0] == 5'h00;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared by read");
    property p_mask_off;
        reg_wr && reg_addr == `ADCSQ_OFF_MASK && reg_wdata[4:0] == 5'h00 |=> !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("interrupt high with mask cleared");
    c_diff: cover property (conv_start && conv_diff);
    c_cmp: cover property (cmp_trig);
    c_irq: cover property ($rose(irq));
endmodule

bind adcsq_ctrl adcsq_ctrl_mon u_mon (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv_start, .conv_input, .conv_diff, .conv_done, .cmp_trig, .irq);
`default_nettype wire

// file: adcsq_ctrl_tb.sv
/*
 * adcsq_ctrl_tb.sv: self-checking bench of the sequencer control block.
 * Assumes the bench itself plays the converter core.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defs.vh"

module adcsq_ctrl_tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ext_trig_pin = 1'b0, timer_trig = 1'b0, pwm_trig = 1'b0;
    logic conv_done = 1'b0;
    logic [11:0] conv_result = 12'h000;
    wire [31:0] reg_rdata;
    wire [3:0] conv_input;
    wire conv_start, conv_diff, cmp_trig, irq;
    int err_total = 0, n_tests = 0, n_start = 0, st = 0, cyc = 0, dly = 0;
    logic [31:0] seed = 32'h0000B829, cur_mux = 32'h0;
    logic [2:0] cur_last = 3'h0;
    logic [7:0] cur_ce = 8'h00;
    logic [3:0] cur_src = 4'h0, cc;
    logic cur_diff = 1'b0, chk_in = 1'b0, exp_cmp = 1'b0, cmp_due = 1'b0;
    logic [11:0] last_res = 12'h000, lo = 12'h100, hi = 12'hEFF;
    logic [3:0] obs_q [$];
    logic [7:0] ra [0:6] = '{`ADCSQ_OFF_ENA, `ADCSQ_OFF_MASK, `ADCSQ_OFF_CMPLO, `ADCSQ_OFF_CMPHI,
        `ADCSQ_OFF_CTRL0, `ADCSQ_OFF_MUX0, 8'hFC};
    logic [31:0] rv [0:6] = '{32'h0, 32'h0, 32'h0, 32'hFFF, 32'h0, 32'h0, 32'h0};
    logic [3:0] srcs [0:3] = '{`ADCSQ_TRG_PROC, `ADCSQ_TRG_EXT, `ADCSQ_TRG_TMR, `ADCSQ_TRG_PWM};

    adcsq_ctrl uut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig_pin(ext_trig_pin), .timer_trig(timer_trig),
        .pwm_trig(pwm_trig), .conv_start(conv_start), .conv_input(conv_input), .conv_diff(conv_diff),
        .conv_done(conv_done), .conv_result(conv_result), .cmp_trig(cmp_trig), .irq(irq));

    // 20 MHz clock
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] mk(input logic [2:0] last, input logic [7:0] ie, input logic [7:0] ce,
        input logic [3:0] src, input logic [1:0] pri, input logic diff);
        return {1'b0, diff, pri, src, ce, ie, 5'h00, last};
    endfunction

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ceiling far above the several hundred cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done;
        end
    end

    // converter stand-in and one-step-late comparator model
    always @(posedge ref_clk) begin
        conv_done <= 1'b0;
        if (cmp_due) begin
            chk_bit(cmp_trig, exp_cmp);
        end
        cmp_due = conv_done;
        if (conv_done) begin
            exp_cmp = st < cur_last && cur_ce[st + 1] && conv_result >= lo && conv_result <= hi
                && !(st + 1 == cur_last && cur_src != `ADCSQ_TRG_ALWAYS);
            last_res = conv_result;
            st = (st == cur_last) ? 0 : st + 1;
        end
        if (conv_start) begin
            n_start++;
            obs_q.push_back(conv_input);
            cc = cur_mux[4 * st +: 4];
            if (chk_in) begin
                chk_val({27'h0, conv_diff, conv_input},
                    {27'h0, cur_diff, cur_diff ? {cc[3], cc[1:0], 1'b0} : cc});
            end
            seed = xs(seed);
            dly = 1 + seed[3:0] % 3;
            conv_result <= seed[27:16];
        end else if (dly > 0) begin
            dly--;
            if (dly == 0) begin
                conv_done <= 1'b1;
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic trig(input logic [3:0] src, input int s);
        case (src)
            `ADCSQ_TRG_PROC: wr(`ADCSQ_OFF_PSSI, 32'h1 << s);
            `ADCSQ_TRG_EXT: begin
                @(posedge ref_clk);
                ext_trig_pin <= 1'b1;
                repeat (4) @(posedge ref_clk);
                ext_trig_pin <= 1'b0;
            end
            default: begin
                @(posedge ref_clk);
                {timer_trig, pwm_trig} <= (src == `ADCSQ_TRG_TMR) ? 2'b10 : 2'b01;
                @(posedge ref_clk);
                {timer_trig, pwm_trig} <= 2'b00;
            end
        endcase
    endtask

    task automatic wait_n(input int n);
        int k;
        for (k = 0; k < 400 && n_start < n; k++) @(posedge ref_clk);
    endtask

    // fourth sequencer modelled with one step
    task automatic cfg(input int s, input logic [31:0] ctrl, input logic [31:0] mux);
        cur_last = (s == 3) ? 3'h0 : ctrl[2:0];
        cur_ce = ctrl[23:16];
        cur_src = ctrl[27:24];
        cur_diff = ctrl[30];
        cur_mux = mux;
        st = 0;
        n_start = 0;
        chk_in = 1'b1;
        wr(`ADCSQ_OFF_CTRL0 + 8'(4 * s), ctrl);
        wr(`ADCSQ_OFF_MUX0 + 8'(4 * s), mux);
        wr(`ADCSQ_OFF_ENA, 32'h1 << s);
    endtask

    task automatic fin(input int n);
        wait_n(n);
        repeat (20) @(posedge ref_clk);
        chk_val(n_start, n);
    endtask

    task automatic run(input int s, input logic [31:0] ctrl, input logic [31:0] mux, input int n);
        cfg(s, ctrl, mux);
        trig(ctrl[27:24], s);
        fin(n);
    endtask

    initial begin
        logic [31:0] v;
        int i, p1, p2;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        for (i = 0; i < 7; i++) begin
            rd(ra[i], v);
            chk_val(v, rv[i]);
        end
        $display("test reset values done");
        wr(`ADCSQ_OFF_CMPLO, {20'h0, lo});
        wr(`ADCSQ_OFF_CMPHI, {20'h0, hi});
        wr(`ADCSQ_OFF_MASK, 32'h1F);
        run(0, mk(3'h7, 8'h80, 8'h00, `ADCSQ_TRG_PROC, 2'h0, 1'b1), 32'hBA983210, 8);
        rd(`ADCSQ_OFF_RESULT, v);
        chk_val(v, {18'h0, 2'h0, last_res});
        chk_bit(irq, 1'b1);
        rd(`ADCSQ_OFF_STATUS, v);
        chk_val(v, 32'h1);
        rd(`ADCSQ_OFF_STATUS, v);
        chk_val(v, 32'h0);
        chk_bit(irq, 1'b0);
        $display("test pair codes and interrupt done");
        wr(`ADCSQ_OFF_MASK, 32'h0);
        // each listed source; comparator step last or next to last
        for (i = 0; i < 8; i++) begin
            run(0, mk(3'(1 + i % 2), 8'h00, 8'h06, srcs[i / 2], 2'h0, 1'b0), 32'h321, 2 + i % 2);
        end
        chk_bit(irq, 1'b0);
        $display("test comparator done");
        run(3, mk(3'h7, 8'h00, 8'h00, `ADCSQ_TRG_PROC, 2'h0, 1'b0), 32'h00000007, 1);
        rd(`ADCSQ_OFF_CTRL0 + 8'hC, v);
        chk_val({29'h0, v[2:0]}, 32'h0);
        $display("test single step done");
        for (i = 0; i < 2; i++) begin
            p1 = i ? 3 : 0;
            p2 = i ? 1 : 2;
            wr(`ADCSQ_OFF_CTRL0 + 8'h4, mk(3'h0, 8'h00, 8'h00, `ADCSQ_TRG_PROC, 2'(p1), 1'b0));
            cfg(2, mk(3'h0, 8'h00, 8'h00, `ADCSQ_TRG_PROC, 2'(p2), 1'b0), 32'h5);
            cfg(3, mk(3'h0, 8'h00, 8'h00, `ADCSQ_TRG_PROC, 2'(3 - p2), 1'b0), 32'h9);
            wr(`ADCSQ_OFF_ENA, 32'hC);
            chk_in = 1'b0;
            obs_q.delete();
            wr(`ADCSQ_OFF_PSSI, 32'hC);
            fin(2);
            chk_val({28'h0, obs_q[0]}, (p1 <= p2) ? 32'h5 : 32'h9);
            chk_val({28'h0, obs_q[1]}, (p1 <= p2) ? 32'h9 : 32'h5);
        end
        $display("test arbitration done");
        cfg(0, mk(3'h1, 8'h02, 8'h00, `ADCSQ_TRG_TMR, 2'h0, 1'b0), 32'h54);
        trig(`ADCSQ_TRG_TMR, 0);
        wait_n(1);
        trig(`ADCSQ_TRG_PROC, 0);
        fin(4);
        cfg(0, mk(3'h1, 8'h02, 8'h00, `ADCSQ_TRG_TMR, 2'h0, 1'b0), 32'h54);
        trig(`ADCSQ_TRG_TMR, 0);
        wait_n(1);
        trig(`ADCSQ_TRG_TMR, 0);
        wait_n(8);
        chk_bit(n_start >= 8, 1'b1);
        rd(`ADCSQ_OFF_STATUS, v);
        chk_bit(v[0], 1'b1);
        // only disabling ends continuous sampling
        wr(`ADCSQ_OFF_ENA, 32'h0);
        repeat (20) @(posedge ref_clk);
        p1 = n_start;
        repeat (40) @(posedge ref_clk);
        chk_val(n_start, p1);
        $display("test retrigger done");
        test_done;
    end
endmodule
`default_nettype wire
